//--- logic/drs_run_select.sv
// Run-command, direction and step-frequency selection for a motor drive
`timescale 1ns/1ps
`include "drs_cfg.svh"
module drs_run_select #(
   parameter int NUM_TERM = 8,
   parameter int FREQ_W = 16
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [NUM_TERM-1:0] term_in,
   input wire logic [NUM_TERM*5-1:0] term_function_in,
   input wire logic [1:0] run_source_sel_in,
   input wire logic [2:0] freq_source_sel_in,
   input wire logic [FREQ_W-1:0] freq_cmd_in,
   input wire logic [FREQ_W-1:0] step_freq_one_in,
   input wire logic [FREQ_W-1:0] step_freq_two_in,
   input wire logic [FREQ_W-1:0] step_freq_three_in,
   input wire logic [FREQ_W-1:0] step_freq_four_in,
   input wire logic [FREQ_W-1:0] step_freq_five_in,
   input wire logic [FREQ_W-1:0] step_freq_six_in,
   input wire logic [FREQ_W-1:0] step_freq_seven_in,
   input wire drs_pkg::drs_keys_t local_keys_in,
   input wire drs_pkg::drs_keys_t remote_keys_in,
   input wire logic remote_connected_in,
   input wire logic keypad_dir_sel_in,
   input wire logic serial_run_in,
   input wire logic serial_rev_in,
   input wire drs_pkg::drs_serial_cfg_t serial_cfg_in,
   input wire logic bipolar_voltage_input_neg_in,
   input wire logic [1:0] direction_inhibit_sel_in,
   input wire logic power_on_start_en_in,
   input wire logic fault_reset_restart_en_in,
   input wire logic fault_active_in,
   input wire logic zero_speed_in,
   output drs_pkg::drs_cmd_t cmd_out,
   output drs_pkg::drs_serial_cfg_t serial_cfg_out,
   output logic [1:0] run_source_out
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // True when any terminal with this function code is on
   function automatic logic term_has(input logic [NUM_TERM-1:0] lvl,
                                     input logic [NUM_TERM*5-1:0] fn,
                                     input logic [4:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_TERM; i++)
         if (lvl[i] && fn[i*5 +: 5] == code)
            hit = 1'b1;
      return hit;
   endfunction : term_has

   // Stored step values beyond the top of range are held at the top
   function automatic logic [FREQ_W-1:0] clamp_freq(input logic [FREQ_W-1:0] f);
      return (f > FREQ_W'(`DRS_FREQ_MAX)) ? FREQ_W'(`DRS_FREQ_MAX) : f;
   endfunction : clamp_freq

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [NUM_TERM-1:0] term_meta;
   logic [NUM_TERM-1:0] term_sync;
   logic [3:0] key_meta;
   logic [3:0] key_sync;
   logic [3:0] key_prev;
   logic fault_meta;
   logic fault_sync;
   logic fault_prev;
   // Two flops per pin; keys and fault get a third stage, compared with the second for edge detection
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         term_meta <= '0;
         term_sync <= '0;
         key_meta <= 4'h0;
         key_sync <= 4'h0;
         key_prev <= 4'h0;
         fault_meta <= 1'b0;
         fault_sync <= 1'b0;
         fault_prev <= 1'b0;
      end
      else
      begin
         term_meta <= term_in;
         term_sync <= term_meta;
         key_meta <= {local_keys_in, remote_keys_in};
         key_sync <= key_meta;
         key_prev <= key_sync;
         fault_meta <= fault_active_in;
         fault_sync <= fault_meta;
         fault_prev <= fault_sync;
      end
   end

   // ----------------------------------------
   // Configuration capture
   // ----------------------------------------
   logic [1:0] run_src;
   logic [2:0] freq_src;
   drs_pkg::drs_serial_cfg_t ser_cfg;

   // Out-of-range serial settings are refused and the old value kept
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         run_src <= `DRS_SRC_RST;
         freq_src <= `DRS_FSRC_RST;
         ser_cfg.protocol <= `DRS_PROTO_RST;
         ser_cfg.station <= `DRS_STATION_RST;
         ser_cfg.baud <= `DRS_BAUD_RST;
      end
      else
      begin
         run_src <= run_source_sel_in;
         freq_src <= freq_source_sel_in;
         if (serial_cfg_in.protocol <= `DRS_PROTO_MAX)
            ser_cfg.protocol <= serial_cfg_in.protocol;
         if (serial_cfg_in.station >= `DRS_STATION_MIN &&
             serial_cfg_in.station <= `DRS_STATION_MAX)
            ser_cfg.station <= serial_cfg_in.station;
         if (serial_cfg_in.baud <= `DRS_BAUD_MAX)
            ser_cfg.baud <= serial_cfg_in.baud;
      end
   end

   // ----------------------------------------
   // Terminal decode
   // ----------------------------------------
   logic fx_on;
   logic rx_on;
   logic [2:0] step_raw;
   logic term_mode;

   // Forward, reverse and step bits from the terminal function table
   always_comb
   begin
      fx_on = term_has(term_sync, term_function_in, `DRS_FN_FWD);
      rx_on = term_has(term_sync, term_function_in, `DRS_FN_REV);
      step_raw[0] = term_has(term_sync, term_function_in, `DRS_FN_STEP_LO);
      step_raw[1] = term_has(term_sync, term_function_in, `DRS_FN_STEP_MID);
      step_raw[2] = term_has(term_sync, term_function_in, `DRS_FN_STEP_HI);
      term_mode = (run_src == `DRS_SRC_TERM1) || (run_src == `DRS_SRC_TERM2);
   end

   // ----------------------------------------
   // Keypad
   // ----------------------------------------
   drs_pkg::drs_keys_t keys_now;
   drs_pkg::drs_keys_t keys_old;
   logic key_run_press;
   logic key_stop_press;
   logic key_run;

   // Only one keypad is live; the remote one takes over when present
   always_comb
   begin
      keys_now = remote_connected_in ? key_sync[1:0] : key_sync[3:2];
      keys_old = remote_connected_in ? key_prev[1:0] : key_prev[3:2];
      key_run_press = keys_now.run && !keys_old.run;
      key_stop_press = keys_now.stop && !keys_old.stop;
   end

   // Stop beats run in one cycle: safer to lose a start than a stop
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         key_run <= 1'b0;
      else if (key_stop_press || fault_sync || run_src != `DRS_SRC_KEYPAD)
         key_run <= 1'b0;
      else if (key_run_press && freq_cmd_in != '0)
         key_run <= 1'b1;
   end

   // ----------------------------------------
   // Terminal arming: power-on and fault restart
   // ----------------------------------------
   logic [1:0] boot_cnt;
   logic term_arm;
   logic term_run_raw;
   // In mode 1 the reverse terminal is a run command of its own
   assign term_run_raw = fx_on || (rx_on && run_src == `DRS_SRC_TERM1);

   // A terminal already on at power-up runs only if enabled; at fault clear, if still armed, it runs one cycle before the enable takes hold
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         boot_cnt <= 2'h0;
         term_arm <= 1'b0;
      end
      else if (boot_cnt != `DRS_BOOT_DONE)
      begin
         boot_cnt <= boot_cnt + 2'h1;
         term_arm <= power_on_start_en_in || !term_run_raw;
      end
      else if (fault_prev && !fault_sync)
         term_arm <= fault_reset_restart_en_in || !term_run_raw;
      else if (!term_run_raw && !rx_on)
         term_arm <= 1'b1;
   end

   // ----------------------------------------
   // Run request and direction
   // ----------------------------------------
   logic want_run;
   logic want_rev;
   logic src_rev;
   logic blocked;

   // Source decode, polarity flip, then inhibit
   always_comb
   begin
      want_run = 1'b0;
      src_rev = `DRS_DIR_F;
      unique case (run_src)
         `DRS_SRC_KEYPAD:
         begin
            want_run = key_run;
            src_rev = keypad_dir_sel_in;
         end
         `DRS_SRC_TERM1:
         begin
            want_run = (fx_on ^ rx_on) && term_arm;
            src_rev = rx_on && !fx_on;
         end
         `DRS_SRC_TERM2:
         begin
            want_run = fx_on && term_arm;
            src_rev = rx_on;
         end
         `DRS_SRC_SERIAL:
         begin
            want_run = serial_run_in;
            src_rev = serial_rev_in;
         end
      endcase
      want_rev = src_rev;
      if (freq_src == `DRS_FSRC_BIPOLAR)
         want_rev = src_rev ^ bipolar_voltage_input_neg_in;
      blocked = (direction_inhibit_sel_in == `DRS_INH_FWD && !want_rev) ||
                (direction_inhibit_sel_in == `DRS_INH_REV && want_rev);
      if (blocked || fault_sync || boot_cnt != `DRS_BOOT_DONE)
         want_run = 1'b0;
   end

   // ----------------------------------------
   // Run state machine
   // ----------------------------------------
   drs_pkg::drs_state_t state;
   drs_pkg::drs_state_t next_state;
   logic cur_rev;
   logic next_cur_rev;

   // A direction change while running passes through DRS_TURN first, until zero speed
   always_comb
   begin
      next_state = state;
      next_cur_rev = cur_rev;
      unique case (state)
         drs_pkg::DRS_STOP:
         begin
            if (want_run)
            begin
               next_state = drs_pkg::DRS_RUN;
               next_cur_rev = want_rev;
            end
         end
         drs_pkg::DRS_RUN:
         begin
            if (!want_run)
               next_state = drs_pkg::DRS_STOP;
            else if (want_rev != cur_rev)
               next_state = drs_pkg::DRS_TURN;
         end
         drs_pkg::DRS_TURN:
         begin
            if (!want_run)
               next_state = drs_pkg::DRS_STOP;
            else if (zero_speed_in)
            begin
               next_state = drs_pkg::DRS_RUN;
               next_cur_rev = want_rev;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state <= drs_pkg::DRS_STOP;
         cur_rev <= `DRS_DIR_F;
      end
      else
      begin
         state <= next_state;
         cur_rev <= next_cur_rev;
      end
   end

   // ----------------------------------------
   // Step index and target frequency
   // ----------------------------------------
   logic [2:0] step_idx;
   logic [FREQ_W-1:0] target;

   // Step bits count only while a run command stands
   always_comb
   begin
      step_idx = want_run ? step_raw : 3'h0;
      unique case (step_idx)
         3'h0: target = freq_cmd_in;
         3'h1: target = clamp_freq(step_freq_one_in);
         3'h2: target = clamp_freq(step_freq_two_in);
         3'h3: target = clamp_freq(step_freq_three_in);
         3'h4: target = clamp_freq(step_freq_four_in);
         3'h5: target = clamp_freq(step_freq_five_in);
         3'h6: target = clamp_freq(step_freq_six_in);
         3'h7: target = clamp_freq(step_freq_seven_in);
      endcase
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // All outputs straight from flops, one cycle after the decision
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cmd_out <= '0;
         serial_cfg_out <= '0;
         run_source_out <= `DRS_SRC_RST;
      end
      else
      begin
         cmd_out.run <= (next_state == drs_pkg::DRS_RUN);
         cmd_out.rev <= next_cur_rev;
         cmd_out.turning <= (next_state == drs_pkg::DRS_TURN);
         cmd_out.step <= step_idx;
         cmd_out.freq <= target;
         serial_cfg_out <= ser_cfg;
         run_source_out <= run_src;
      end
   end

endmodule : drs_run_select

//--- logic/drs_cfg.svh
// Constants for the drive run-command and step-select block
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
// ----------------------------------------
// Run source and frequency source codes
// ----------------------------------------
`define DRS_SRC_KEYPAD 2'h0
`define DRS_SRC_TERM1 2'h1
`define DRS_SRC_TERM2 2'h2
`define DRS_SRC_SERIAL 2'h3
`define DRS_SRC_RST 2'h1
`define DRS_FSRC_BIPOLAR 3'h2
`define DRS_FSRC_RST 3'h0
// ----------------------------------------
// Terminal function codes
// ----------------------------------------
`define DRS_FN_FWD 5'h00
`define DRS_FN_REV 5'h01
`define DRS_FN_STEP_LO 5'h05
`define DRS_FN_STEP_MID 5'h06
`define DRS_FN_STEP_HI 5'h07
// ----------------------------------------
// Direction, inhibit and limits
// ----------------------------------------
`define DRS_DIR_F 1'h0
`define DRS_DIR_R 1'h1
`define DRS_INH_NONE 2'h0
`define DRS_INH_FWD 2'h1
`define DRS_INH_REV 2'h2
`define DRS_FREQ_MAX 16'h9C40
`define DRS_PROTO_MAX 1'h1
`define DRS_PROTO_RST 1'h0
`define DRS_STATION_MIN 6'h01
`define DRS_STATION_MAX 6'h20
`define DRS_STATION_RST 6'h01
`define DRS_BAUD_MAX 3'h4
`define DRS_BAUD_RST 3'h3
`define DRS_BOOT_DONE 2'h3
`endif

//--- logic/drs_pkg.sv
// Types shared by the drive run-command and step-select block
package drs_pkg;
   // Run state of the command path
   typedef enum logic [1:0] {DRS_STOP, DRS_RUN, DRS_TURN} drs_state_t;
   // Key pair from one keypad
   typedef struct packed {
      logic run;
      logic stop;
   } drs_keys_t;
   // Serial link settings
   typedef struct packed {
      logic protocol;
      logic [5:0] station;
      logic [2:0] baud;
   } drs_serial_cfg_t;
   // Resolved drive command
   typedef struct packed {
      logic run;
      logic rev;
      logic turning;
      logic [2:0] step;
      logic [15:0] freq;
   } drs_cmd_t;
endpackage : drs_pkg

//--- test/drs_run_monitor.sv
// Port-level checks for the run-select block
`timescale 1ns/1ps
`include "drs_cfg.svh"
module drs_run_monitor #(
   parameter int NUM_TERM = 8,
   parameter int FREQ_W = 16
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [NUM_TERM-1:0] term_in,
   input wire logic [NUM_TERM*5-1:0] term_function_in,
   input wire logic [FREQ_W-1:0] freq_cmd_in,
   input wire logic [1:0] direction_inhibit_sel_in,
   input wire logic fault_active_in,
   input wire logic zero_speed_in,
   input wire drs_pkg::drs_cmd_t cmd_out,
   input wire drs_pkg::drs_serial_cfg_t serial_cfg_out,
   input wire logic [1:0] run_source_out
);
   // Single domain, so one clock and one disable serve all
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   AST_SRC_RST: assert property ($rose(rst_b_in) |-> run_source_out == `DRS_SRC_RST)
      else $error("run source wrong at reset exit");
   AST_STEP_CAP: assert property (cmd_out.run && cmd_out.step != 3'h0 |->
      cmd_out.freq <= `DRS_FREQ_MAX)
      else $error("step frequency above limit");
   AST_STEP0: assert property (cmd_out.run && cmd_out.step == 3'h0
      && $stable(freq_cmd_in) |-> cmd_out.freq == freq_cmd_in)
      else $error("step 0 frequency wrong");
   AST_IDLE_STEP: assert property (!cmd_out.run && !cmd_out.turning |->
      cmd_out.step == 3'h0)
      else $error("step index while stopped");
   AST_BOTH_STOP: assert property ((run_source_out == `DRS_SRC_TERM1
      && term_in[1:0] == 2'h3 && term_function_in[9:0] == 10'h020)[*4] |-> !cmd_out.run)
      else $error("run with both terminals on");
   AST_TURN_HALT: assert property (cmd_out.turning |-> !cmd_out.run)
      else $error("run while turning");
   AST_TURN_END: assert property (cmd_out.turning && zero_speed_in |=> !cmd_out.turning)
      else $error("turn not ended at standstill");
   AST_INH_FWD: assert property ((direction_inhibit_sel_in == `DRS_INH_FWD)[*2] |->
      !(cmd_out.run && !cmd_out.rev))
      else $error("forward run while blocked");
   AST_INH_REV: assert property ((direction_inhibit_sel_in == `DRS_INH_REV)[*2] |->
      !(cmd_out.run && cmd_out.rev))
      else $error("reverse run while blocked");
   AST_FAULT_HOLD: assert property (fault_active_in[*4] |-> !cmd_out.run)
      else $error("run while faulted");
   AST_CFG_RANGE: assert property (serial_cfg_out.station != 6'h00 |->
      serial_cfg_out.station <= `DRS_STATION_MAX && serial_cfg_out.baud <= `DRS_BAUD_MAX)
      else $error("serial config out of range");
endmodule : drs_run_monitor

bind drs_run_select drs_run_monitor #(.NUM_TERM(NUM_TERM), .FREQ_W(FREQ_W)) u_mon (
   .clk_in(clk_in),
   .rst_b_in(rst_b_in),
   .term_in(term_in),
   .term_function_in(term_function_in),
   .freq_cmd_in(freq_cmd_in),
   .direction_inhibit_sel_in(direction_inhibit_sel_in),
   .fault_active_in(fault_active_in),
   .zero_speed_in(zero_speed_in),
   .cmd_out(cmd_out),
   .serial_cfg_out(serial_cfg_out),
   .run_source_out(run_source_out)
);

//--- test/drs_panel_model.sv
// Keypads, terminal strip and serial host facing the block
`timescale 1ns/1ps
module drs_panel_model (
   input wire logic clk_in,
   output logic [7:0] term_out,
   output drs_pkg::drs_keys_t local_keys_out,
   output drs_pkg::drs_keys_t remote_keys_out,
   output logic serial_run_out,
   output logic serial_rev_out
);
   // All contacts open at power-up
   initial
   begin
      term_out = 8'h00;
      local_keys_out = 2'h0;
      remote_keys_out = 2'h0;
      serial_run_out = 1'h0;
      serial_rev_out = 1'h0;
   end

   // Levels move just after the falling edge
   task automatic set_term(input logic [7:0] v);
      @(negedge clk_in);
      term_out = v;
   endtask : set_term

   // Held four cycles so the synchroniser sees a clean press
   task automatic press(input logic remote, input logic [1:0] k);
      @(negedge clk_in);
      if (remote)
         remote_keys_out = k;
      else
         local_keys_out = k;
      repeat (4) @(negedge clk_in);
      local_keys_out = 2'h0;
      remote_keys_out = 2'h0;
   endtask : press

   // Framing lives elsewhere; only the decoded levels matter here
   task automatic set_serial(input logic run, input logic rev);
      @(negedge clk_in);
      serial_run_out = run;
      serial_rev_out = rev;
   endtask : set_serial
endmodule : drs_panel_model

//--- test/drs_run_select_tb.sv
// Self-checking bench for the run-select block
`timescale 1ns/1ps
module drs_run_select_tb;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [39:0] fn = {5'h07, 5'h06, 5'h05, 5'h1F, 5'h1F, 5'h1F, 5'h01, 5'h00};
   logic [1:0] src = 2'h1;
   logic [2:0] fsrc = 3'h0;
   logic [15:0] fcmd = 16'h01F4;
   logic [15:0] sf [8];
   logic remote = 1'b0;
   logic kdir = 1'b0;
   drs_pkg::drs_serial_cfg_t scfg = {1'h0, 6'h05, 3'h2};
   logic neg = 1'b0;
   logic [1:0] inh = 2'h0;
   logic pos = 1'b0;
   logic frr = 1'b0;
   logic fault = 1'b0;
   logic zero = 1'b1;
   logic [7:0] term;
   drs_pkg::drs_keys_t lkeys;
   drs_pkg::drs_keys_t rkeys;
   logic srun;
   logic srev;
   drs_pkg::drs_cmd_t cmd_out;
   drs_pkg::drs_serial_cfg_t cfg_out;
   logic [1:0] src_out;
   int num_errors = 0;
   int checked = 0;

   // 100 MHz clock
   always #5 clk_in = ~clk_in;

   drs_panel_model u_panel (.clk_in(clk_in), .term_out(term), .local_keys_out(lkeys),
      .remote_keys_out(rkeys), .serial_run_out(srun), .serial_rev_out(srev));

   drs_run_select DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .term_in(term),
      .term_function_in(fn), .run_source_sel_in(src), .freq_source_sel_in(fsrc),
      .freq_cmd_in(fcmd), .step_freq_one_in(sf[1]), .step_freq_two_in(sf[2]),
      .step_freq_three_in(sf[3]), .step_freq_four_in(sf[4]), .step_freq_five_in(sf[5]),
      .step_freq_six_in(sf[6]), .step_freq_seven_in(sf[7]), .local_keys_in(lkeys),
      .remote_keys_in(rkeys), .remote_connected_in(remote), .keypad_dir_sel_in(kdir),
      .serial_run_in(srun), .serial_rev_in(srev), .serial_cfg_in(scfg),
      .bipolar_voltage_input_neg_in(neg), .direction_inhibit_sel_in(inh),
      .power_on_start_en_in(pos), .fault_reset_restart_en_in(frr),
      .fault_active_in(fault), .zero_speed_in(zero), .cmd_out(cmd_out),
      .serial_cfg_out(cfg_out), .run_source_out(src_out));

   // Expected command word for a running drive
   function automatic drs_pkg::drs_cmd_t want(input logic rev, input logic [2:0] st);
      want = '0;
      want.run = 1'b1;
      want.rev = rev;
      want.step = st;
      // Stored steps top out at 400 Hz, in 0.01 Hz units
      want.freq = (st == 3'h0) ? fcmd : ((sf[st] > 16'h9C40) ? 16'h9C40 : sf[st]);
   endfunction : want

   task automatic chk(input logic [22:0] seen, input logic [22:0] exp_v);
      checked++;
      if (seen !== exp_v)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp_v);
      end
   endtask : chk

   // Wait covers sync, output flop and one turn-round cycle
   task automatic settle;
      repeat (8) @(negedge clk_in);
   endtask : settle

   task automatic finish_test;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // Hang guard, far beyond the few hundred cycles of the tests
   initial
   begin
      repeat (5000) @(posedge clk_in);
      num_errors++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h7FED895C));
      for (int i = 1; i < 8; i++)
         sf[i] = 16'($urandom % 32'h9C41);
      sf[0] = 16'h0000;
      // Corners: far above the ceiling and exactly on it
      sf[6] = 16'hFFFF;
      sf[7] = 16'h9C40;
      repeat (2) @(negedge clk_in);
      chk(23'(src_out), 23'h1);
      rst_b_in = 1'b1;
      settle();
      chk(23'(cfg_out), 23'(scfg));
      scfg.station = 6'h00;
      settle();
      chk(23'(cfg_out), 23'h02A);
      scfg = {1'h1, 6'h20, 3'h5};
      settle();
      chk(23'(cfg_out), 23'h302);
      // Forward terminal and all eight steps, twice, with fresh stored values for steps 1 to 5 the second time
      for (int i = 0; i < 16; i++)
      begin
         fcmd = 16'($urandom % 32'h9C40) + 16'h0001;
         if (i == 8)
            for (int j = 1; j < 6; j++)
               sf[j] = 16'($urandom);
         u_panel.set_term({3'(i), 5'h01});
         settle();
         chk(cmd_out, want(1'b0, 3'(i)));
      end
      // Step bit 0 moved to another terminal, the old one freed
      fn[19:15] = 5'h05;
      fn[29:25] = 5'h1F;
      u_panel.set_term(8'h09);
      settle();
      chk(cmd_out, want(1'b0, 3'h1));
      u_panel.set_term(8'h21);
      settle();
      chk(cmd_out, want(1'b0, 3'h0));
      u_panel.set_term(8'h03);
      settle();
      chk(23'(cmd_out.run), 23'h0);
      u_panel.set_term(8'h01);
      inh = 2'h1;
      settle();
      chk(23'(cmd_out.run), 23'h0);
      inh = 2'h2;
      settle();
      chk(cmd_out, want(1'b0, 3'h0));
      inh = 2'h0;
      src = 2'h2;
      u_panel.set_term(8'h03);
      settle();
      chk(cmd_out, want(1'b1, 3'h0));
      chk(23'(src_out), 23'h2);
      u_panel.set_term(8'h01);
      settle();
      chk(cmd_out, want(1'b0, 3'h0));
      // Fault clear with and without restart
      fault = 1'b1;
      settle();
      frr = 1'b1;
      fault = 1'b0;
      settle();
      chk(cmd_out, want(1'b0, 3'h0));
      frr = 1'b0;
      fault = 1'b1;
      settle();
      fault = 1'b0;
      settle();
      chk(23'(cmd_out.run), 23'h0);
      u_panel.set_term(8'h00);
      u_panel.set_term(8'h01);
      settle();
      // Polarity flip: halt, wait for standstill, then reverse
      fsrc = 3'h2;
      zero = 1'b0;
      neg = 1'b1;
      settle();
      chk({cmd_out.turning, cmd_out.run}, 23'h2);
      zero = 1'b1;
      settle();
      chk(cmd_out, want(1'b1, 3'h0));
      neg = 1'b0;
      fsrc = 3'h0;
      u_panel.set_term(8'h00);
      // Keypad, built-in then remote
      src = 2'h0;
      kdir = 1'b1;
      u_panel.press(1'b0, 2'h2);
      settle();
      chk(cmd_out, want(1'b1, 3'h0));
      u_panel.press(1'b0, 2'h1);
      settle();
      chk(23'(cmd_out.run), 23'h0);
      remote = 1'b1;
      u_panel.press(1'b0, 2'h2);
      settle();
      chk(23'(cmd_out.run), 23'h0);
      kdir = 1'b0;
      u_panel.press(1'b1, 2'h2);
      settle();
      chk(cmd_out, want(1'b0, 3'h0));
      u_panel.press(1'b1, 2'h1);
      // Serial run both ways
      src = 2'h3;
      u_panel.set_serial(1'b1, 1'b0);
      settle();
      chk(cmd_out, want(1'b0, 3'h0));
      u_panel.set_serial(1'b1, 1'b1);
      settle();
      chk(cmd_out, want(1'b1, 3'h0));
      u_panel.set_serial(1'b0, 1'b0);
      // Power-up with forward or reverse terminal already closed
      src = 2'h1;
      // Forward, then mode 1 reverse, already closed at power-up
      for (int p = 0; p < 4; p++)
      begin
         pos = p[0];
         u_panel.set_term(p[1] ? 8'h02 : 8'h01);
         rst_b_in = 1'b0;
         repeat (2) @(negedge clk_in);
         rst_b_in = 1'b1;
         settle();
         chk(23'(cmd_out.run), 23'(p[0]));
      end
      finish_test();
   end
endmodule : drs_run_select_tb
